// *** core/iplr_regs.sv ***
// Interrupt priority level registers with level arbitration
`timescale 1ns/1ps
module iplr_regs (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic [7:0] bit_addr_in,
  input wire logic bit_val_in,
  input wire logic bit_wr_in,
  input wire logic bit_rd_in,
  output logic bit_rdata_out,
  input wire logic [10:0] src_req_in,
  input wire logic [10:0] src_en_in,
  input wire logic global_irq_enable_in,
  output logic irq_req_out,
  output logic [3:0] irq_src_out,
  output logic [1:0] irq_level_out,
  input wire logic irq_ack_in,
  input wire logic irq_ret_in,
  output logic [21:0] src_level_out,
  output logic [3:0] svc_active_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [6:0] low_a;
    logic [6:0] high_a;
    logic [3:0] low_b;
    logic [3:0] high_b;
    logic [7:0] rdata;
    logic bit_rdata;
    logic [3:0] in_svc;
    logic irq;
    logic [3:0] src;
    logic [1:0] lvl;
  } iplr_state_t;

  iplr_state_t st_q;
  iplr_state_t st_d;

  logic [21:0] level_map;
  logic [10:0] req_masked;
  logic svc_busy;
  logic [1:0] svc_level;
  logic win_valid;
  logic [3:0] win_src;
  logic [1:0] win_level;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Bit addressable registers: bit address = register base + index
  function automatic logic bit_hits(input logic [7:0] baddr,
                                    input logic [7:0] base);
    bit_hits = (baddr[7:3] == base[7:3]);
  endfunction

  // Merge one bit write into a register image
  function automatic logic [7:0] set_one(input logic [7:0] img,
                                         input logic [2:0] idx,
                                         input logic val);
    logic [7:0] r;
    r = img;
    r[idx] = val;
    set_one = r;
  endfunction

  // Two-bit level of a source from its high and low bits
  function automatic logic [1:0] lvl_of(input logic hi,
                                        input logic lo);
    lvl_of = {hi, lo};
  endfunction

  // Highest level currently in service
  function automatic logic [1:0] top_svc(input logic [3:0] svc);
    logic [1:0] t;
    t = iplr_pkg::LVL_0;
    for (int i = 0; i < iplr_pkg::NUM_LVL; i++) begin
      if (svc[i]) begin
        t = 2'(i);
      end
    end
    top_svc = t;
  endfunction

  // Register image as seen on a read; reserved bits read as constant
  function automatic logic [7:0] img_a(input logic [6:0] v);
    img_a = {iplr_pkg::RSVD_READ[7], v};
  endfunction

  function automatic logic [7:0] img_b(input logic [3:0] v);
    img_b = {iplr_pkg::RSVD_READ[7:4], v};
  endfunction

  // ****************************************************************
  // Level map per source, in polling order
  // ****************************************************************
  always_comb begin
    level_map = '0;
    level_map[2*iplr_pkg::SRC_EXT0 +: 2] =
        lvl_of(st_q.high_a[iplr_pkg::BIT_EXT0],
               st_q.low_a[iplr_pkg::BIT_EXT0]);
    level_map[2*iplr_pkg::SRC_TIMER0 +: 2] =
        lvl_of(st_q.high_a[iplr_pkg::BIT_TIMER0],
               st_q.low_a[iplr_pkg::BIT_TIMER0]);
    level_map[2*iplr_pkg::SRC_EXT1 +: 2] =
        lvl_of(st_q.high_a[iplr_pkg::BIT_EXT1],
               st_q.low_a[iplr_pkg::BIT_EXT1]);
    level_map[2*iplr_pkg::SRC_TIMER1 +: 2] =
        lvl_of(st_q.high_a[iplr_pkg::BIT_TIMER1],
               st_q.low_a[iplr_pkg::BIT_TIMER1]);
    level_map[2*iplr_pkg::SRC_PCA +: 2] =
        lvl_of(st_q.high_a[iplr_pkg::BIT_PCA],
               st_q.low_a[iplr_pkg::BIT_PCA]);
    level_map[2*iplr_pkg::SRC_SERIAL +: 2] =
        lvl_of(st_q.high_a[iplr_pkg::BIT_SERIAL],
               st_q.low_a[iplr_pkg::BIT_SERIAL]);
    level_map[2*iplr_pkg::SRC_TIMER2 +: 2] =
        lvl_of(st_q.high_a[iplr_pkg::BIT_TIMER2],
               st_q.low_a[iplr_pkg::BIT_TIMER2]);
    level_map[2*iplr_pkg::SRC_CAN +: 2] =
        lvl_of(st_q.high_b[iplr_pkg::BIT_CAN],
               st_q.low_b[iplr_pkg::BIT_CAN]);
    level_map[2*iplr_pkg::SRC_ADC +: 2] =
        lvl_of(st_q.high_b[iplr_pkg::BIT_ADC],
               st_q.low_b[iplr_pkg::BIT_ADC]);
    level_map[2*iplr_pkg::SRC_OVERRUN +: 2] =
        lvl_of(st_q.high_b[iplr_pkg::BIT_OVERRUN],
               st_q.low_b[iplr_pkg::BIT_OVERRUN]);
    level_map[2*iplr_pkg::SRC_SPI +: 2] =
        lvl_of(st_q.high_b[iplr_pkg::BIT_SPI],
               st_q.low_b[iplr_pkg::BIT_SPI]);
  end

  // ****************************************************************
  // Arbitration
  // ****************************************************************

  // Global enable low masks everything regardless of source enables
  assign req_masked = src_req_in & src_en_in &
      {iplr_pkg::NUM_SRC{global_irq_enable_in}};
  assign svc_busy = |st_q.in_svc;
  assign svc_level = top_svc(st_q.in_svc);

  // Arbiter reads registered levels, so a write counts next cycle
  iplr_arb u_arb (
    .req_in(req_masked),
    .level_in(level_map),
    .svc_busy_in(svc_busy),
    .svc_level_in(svc_level),
    .win_valid_out(win_valid),
    .win_src_out(win_src),
    .win_level_out(win_level)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [7:0] la;
    logic [7:0] lb;
    logic [3:0] svc;
    logic [7:0] bimg;
    st_d = st_q;
    bimg = 8'h00;
    la = {1'b0, st_q.low_a};
    lb = {4'h0, st_q.low_b};
    svc = st_q.in_svc;

    // Byte writes; reserved bits are dropped so they read constant
    if (sfr_wr_in) begin
      case (sfr_addr_in)
        iplr_pkg::ADDR_LOW_A: begin
          la = sfr_wdata_in;
        end
        iplr_pkg::ADDR_HIGH_A: begin
          st_d.high_a = sfr_wdata_in[6:0];
        end
        iplr_pkg::ADDR_LOW_B: begin
          lb = sfr_wdata_in;
        end
        iplr_pkg::ADDR_HIGH_B: begin
          st_d.high_b = sfr_wdata_in[3:0];
        end
        default: begin
        end
      endcase
    end

    // Single bit set or clear on the two bit addressable registers
    if (bit_wr_in) begin
      if (bit_hits(bit_addr_in, iplr_pkg::ADDR_LOW_A)) begin
        la = set_one(la, bit_addr_in[2:0], bit_val_in);
      end
      if (bit_hits(bit_addr_in, iplr_pkg::ADDR_LOW_B)) begin
        lb = set_one(lb, bit_addr_in[2:0], bit_val_in);
      end
    end
    st_d.low_a = la[6:0];
    st_d.low_b = lb[3:0];

    // Read data stand for exactly one cycle after the strobe
    st_d.rdata = 8'h00;
    if (sfr_rd_in) begin
      case (sfr_addr_in)
        iplr_pkg::ADDR_LOW_A: begin
          st_d.rdata = img_a(st_q.low_a);
        end
        iplr_pkg::ADDR_HIGH_A: begin
          st_d.rdata = img_a(st_q.high_a);
        end
        iplr_pkg::ADDR_LOW_B: begin
          st_d.rdata = img_b(st_q.low_b);
        end
        iplr_pkg::ADDR_HIGH_B: begin
          st_d.rdata = img_b(st_q.high_b);
        end
        iplr_pkg::ADDR_SVC_STAT: begin
          st_d.rdata = {st_q.irq, st_q.lvl, 1'b0, st_q.in_svc};
        end
        default: begin
          st_d.rdata = 8'h00;
        end
      endcase
    end

    // Bit reads outside the two registers leave the image at zero
    if (bit_rd_in) begin
      if (bit_hits(bit_addr_in, iplr_pkg::ADDR_LOW_A)) begin
        bimg = img_a(st_q.low_a);
      end else if (bit_hits(bit_addr_in, iplr_pkg::ADDR_LOW_B)) begin
        bimg = img_b(st_q.low_b);
      end
    end
    st_d.bit_rdata = bimg[bit_addr_in[2:0]];

    // Service tracking: return leaves the top level, then an
    // acknowledge enters the offered level, so both may coincide
    if (irq_ret_in) begin
      svc[top_svc(st_q.in_svc)] = 1'b0;
    end
    if (irq_ack_in && st_q.irq) begin
      svc[st_q.lvl] = 1'b1;
    end
    st_d.in_svc = svc;

    // Offer held back one cycle after ack or return so the core
    // never sees a stale winner against the old service level
    st_d.irq = win_valid && !irq_ack_in && !irq_ret_in;
    st_d.src = win_valid ? win_src : st_q.src;
    st_d.lvl = win_valid ? win_level : st_q.lvl;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q.low_a <= iplr_pkg::RST_A;
      st_q.high_a <= iplr_pkg::RST_A;
      st_q.low_b <= iplr_pkg::RST_B;
      st_q.high_b <= iplr_pkg::RST_B;
      st_q.rdata <= 8'h00;
      st_q.bit_rdata <= 1'b0;
      st_q.in_svc <= 4'h0;
      st_q.irq <= 1'b0;
      st_q.src <= 4'h0;
      st_q.lvl <= iplr_pkg::LVL_0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sfr_rdata_out = st_q.rdata;
  assign bit_rdata_out = st_q.bit_rdata;
  assign irq_req_out = st_q.irq;
  assign irq_src_out = st_q.src;
  assign irq_level_out = st_q.lvl;
  assign src_level_out = level_map;
  assign svc_active_out = st_q.in_svc;

endmodule

// *** inc/iplr_pkg.sv ***
// Constants and types for the interrupt priority level register block
// Summary of operation
// - Each source level is {high bit, low bit}; 00 lowest, 11 highest.
// - Low register A holds pca, timer2, serial, timer1, ext1, timer0, ext0.
// - Low register B holds spi bit3, overrun bit2, adc bit1, can bit0.
// - High register A at B7h uses the same bit positions as low A.
// - High register B at F7h holds spi, overrun, adc, can high bits.
// - Reserved bits read as constant zero from RSVD_READ; writes drop them.
// - Low register A resets to zero and allows single bit accesses.
// - Low and high register B reset bits 3..0; low B is bit addressable.
// - Low register B sits at address F8h.
// - Only a strictly higher level preempts; level three never preempted.
// - Higher level first; equal levels resolved by fixed polling order.
// - A source competes only when its enable and global enable are set.
package iplr_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_LOW_A = 8'hb8;
  localparam logic [7:0] ADDR_HIGH_A = 8'hb7;
  localparam logic [7:0] ADDR_LOW_B = 8'hf8;
  localparam logic [7:0] ADDR_HIGH_B = 8'hf7;
  localparam logic [7:0] ADDR_SVC_STAT = 8'hf6;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int WIDTH_A = 7;
  localparam int WIDTH_B = 4;
  localparam logic [6:0] RST_A = 7'h00;
  localparam logic [3:0] RST_B = 4'h0;
  localparam logic [7:0] RSVD_READ = 8'h00;
  localparam int BIT_EXT0 = 0;
  localparam int BIT_TIMER0 = 1;
  localparam int BIT_EXT1 = 2;
  localparam int BIT_TIMER1 = 3;
  localparam int BIT_SERIAL = 4;
  localparam int BIT_TIMER2 = 5;
  localparam int BIT_PCA = 6;
  localparam int BIT_CAN = 0;
  localparam int BIT_ADC = 1;
  localparam int BIT_OVERRUN = 2;
  localparam int BIT_SPI = 3;

  // ****************************************************************
  // Sources in polling order, and levels
  // ****************************************************************
  localparam int NUM_SRC = 11;
  localparam int NUM_LVL = 4;
  typedef enum logic [3:0] {
    SRC_EXT0 = 4'h0,
    SRC_TIMER0 = 4'h1,
    SRC_EXT1 = 4'h2,
    SRC_TIMER1 = 4'h3,
    SRC_PCA = 4'h4,
    SRC_SERIAL = 4'h5,
    SRC_TIMER2 = 4'h6,
    SRC_CAN = 4'h7,
    SRC_ADC = 4'h8,
    SRC_OVERRUN = 4'h9,
    SRC_SPI = 4'ha
  } iplr_src_t;
  typedef enum logic [1:0] {
    LVL_0 = 2'h0,
    LVL_1 = 2'h1,
    LVL_2 = 2'h2,
    LVL_3 = 2'h3
  } iplr_lvl_t;

endpackage

// *** core/iplr_arb.sv ***
// Level priority arbiter picking the winning interrupt source, fixed polling order on ties
`timescale 1ns/1ps
module iplr_arb (
  input wire logic [10:0] req_in,
  input wire logic [21:0] level_in,
  input wire logic svc_busy_in,
  input wire logic [1:0] svc_level_in,
  output logic win_valid_out,
  output logic [3:0] win_src_out,
  output logic [1:0] win_level_out
);

  // ****************************************************************
  // Search from the top level down, lowest polling index first
  // ****************************************************************
  always_comb begin
    logic found;
    found = 1'b0;
    win_src_out = 4'h0;
    win_level_out = iplr_pkg::LVL_0;
    for (int l = iplr_pkg::NUM_LVL - 1; l >= 0; l--) begin
      for (int s = 0; s < iplr_pkg::NUM_SRC; s++) begin
        if (!found && req_in[s] &&
            level_in[2*s +: 2] == 2'(l)) begin
          found = 1'b1;
          win_src_out = 4'(s);
          win_level_out = 2'(l);
        end
      end
    end
    // A request only preempts a strictly lower running level
    win_valid_out = found &&
        (!svc_busy_in || win_level_out > svc_level_in);
  end

endmodule

// *** verif/iplr_checker.sv ***
// Assertion checker for the priority level register block
`timescale 1ns/1ps
module iplr_checker (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] bit_addr_in,
  input wire logic bit_val_in,
  input wire logic bit_wr_in,
  input wire logic [10:0] src_req_in,
  input wire logic [10:0] src_en_in,
  input wire logic global_irq_enable_in,
  input wire logic irq_req_out,
  input wire logic [3:0] irq_src_out,
  input wire logic [1:0] irq_level_out,
  input wire logic [21:0] src_level_out,
  input wire logic [3:0] svc_active_out
);
  logic [10:0] live;
  logic [6:0] best;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  assign live = src_req_in & src_en_in & {11{global_irq_enable_in}};
  // Downward scan with >= leaves the lowest polling index on a tie
  always_comb begin
    best = 7'h00;
    for (int i = 10; i >= 0; i--) begin
      if (live[i] && (!best[6] || src_level_out[2*i+:2] >= best[1:0])) begin
        best = {1'b1, 4'(i), src_level_out[2*i+:2]};
      end
    end
  end
  lowa_map_a: assert property (
    sfr_wr_in && !bit_wr_in && sfr_addr_in == iplr_pkg::ADDR_LOW_A |=>
    src_level_out[8] == $past(sfr_wdata_in[6]) &&
    src_level_out[10] == $past(sfr_wdata_in[4])) else $error("low A map");
  higha_map_a: assert property (
    sfr_wr_in && !bit_wr_in && sfr_addr_in == 8'hb7 |=>
    src_level_out[9] == $past(sfr_wdata_in[6]) &&
    src_level_out[3] == $past(sfr_wdata_in[1])) else $error("high A map");
  lowb_map_a: assert property (
    sfr_wr_in && !bit_wr_in && sfr_addr_in == 8'hf8 |=>
    src_level_out[14] == $past(sfr_wdata_in[0]) &&
    src_level_out[20] == $past(sfr_wdata_in[3])) else $error("low B map");
  highb_map_a: assert property (
    sfr_wr_in && !bit_wr_in && sfr_addr_in == 8'hf7 |=>
    src_level_out[15] == $past(sfr_wdata_in[0]) &&
    src_level_out[21] == $past(sfr_wdata_in[3])) else $error("high B map");
  bit_write_a: assert property (
    bit_wr_in && bit_addr_in == iplr_pkg::ADDR_LOW_A + 8'h06 |=>
    src_level_out[8] == $past(bit_val_in)) else $error("bit write lost");
  mask_off_a: assert property (
    !global_irq_enable_in |=> !irq_req_out) else $error("masked offer");
  winner_a: assert property (
    irq_req_out |-> $past(best[6]) &&
    {irq_src_out, irq_level_out} == $past(best[5:0])) else $error("winner");
  preempt_a: assert property (
    irq_req_out |-> ($past(svc_active_out) >> irq_level_out) == 4'h0)
    else $error("offer not above active level");
  top_block_a: assert property (
    svc_active_out[3] |=> !irq_req_out) else $error("level 3 preempted");
endmodule

// *** verif/iplr_core_model.sv ***
// Behavioural core that accepts offered interrupts
`timescale 1ns/1ps
module iplr_core_model (
  input wire logic core_clk_in,
  input wire logic irq_req_in,
  input wire logic ack_en_in,
  output logic irq_ack_out
);
  initial irq_ack_out = 1'b0;
  // Acks one cycle late, as a core finishing an instruction would
  always @(posedge core_clk_in)
    irq_ack_out <= irq_req_in && ack_en_in && !irq_ack_out;
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the priority level register block
`timescale 1ns/1ps
module testbench;
  logic clk, nrst, wr, rd, bwr, brd, bval, gen, ack_en, ret;
  logic brdata, req_o, ack;
  logic [7:0] addr, wdata, baddr, rdata;
  logic [10:0] req, en;
  logic [3:0] src, svc;
  logic [1:0] lvl;
  logic [21:0] lvls;
  logic [7:0] ra [4] = '{iplr_pkg::ADDR_LOW_A, 8'hb7, 8'hf8, 8'hf7};
  logic [7:0] wd [4] = '{8'h55, 8'h2a, 8'h05, 8'h0a};
  int num_errors, checks;
  iplr_regs iplr_regs_i (.core_clk_in(clk), .nrst_in(nrst),
    .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_wr_in(wr),
    .sfr_rd_in(rd), .sfr_rdata_out(rdata), .bit_addr_in(baddr),
    .bit_val_in(bval), .bit_wr_in(bwr), .bit_rd_in(brd),
    .bit_rdata_out(brdata), .src_req_in(req), .src_en_in(en),
    .global_irq_enable_in(gen), .irq_req_out(req_o), .irq_src_out(src),
    .irq_level_out(lvl), .irq_ack_in(ack), .irq_ret_in(ret),
    .src_level_out(lvls), .svc_active_out(svc));
  iplr_core_model iplr_core_model_i (.core_clk_in(clk), .irq_req_in(req_o),
    .ack_en_in(ack_en), .irq_ack_out(ack));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic bit_op(input logic [7:0] a, input logic v);
    @(posedge clk);
    baddr <= a;
    bval <= v;
    bwr <= 1'b1;
    @(posedge clk);
    bwr <= 1'b0;
    brd <= 1'b1;
    @(posedge clk);
    brd <= 1'b0;
    #1 chk(brdata, v);
  endtask
  // Offer is registered one edge after the request is seen
  task automatic offer(input logic [10:0] r, input logic e,
                       input logic [3:0] s, input logic [1:0] l);
    @(posedge clk);
    req <= r;
    repeat (2) @(posedge clk);
    #1 chk(req_o, e);
    if (e) chk({src, lvl}, {s, l});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {nrst, wr, rd, bwr, brd, bval, ack_en, ret} = 8'h00;
    {addr, wdata, baddr, req} = 35'h0;
    gen = 1'b1;
    en = 11'h7ff;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    foreach (ra[i]) rreg(ra[i], 8'h00);
    foreach (ra[i]) wreg(ra[i], wd[i]);
    foreach (ra[i]) rreg(ra[i], wd[i]);
    chk(lvls, 22'h266599);
    rreg(8'hf5, 8'h00);
    $display("test registers done");
    bit_op(iplr_pkg::ADDR_LOW_A + 8'h06, 1'b0);
    bit_op(8'hfb, 1'b1);
    rreg(ra[0], 8'h15);
    rreg(ra[2], 8'h0d);
    $display("test bit access done");
    offer(11'h003, 1'b1, 4'h1, 2'h2);
    offer(11'h005, 1'b1, 4'h0, 2'h1);
    offer(11'h140, 1'b1, 4'h6, 2'h2);
    offer(11'h010, 1'b1, 4'h4, 2'h0);
    offer(11'h400, 1'b1, 4'ha, 2'h3);
    @(posedge clk) gen <= 1'b0;
    offer(11'h7ff, 1'b0, 4'h0, 2'h0);
    @(posedge clk) {gen, en} <= {1'b1, 11'h3ff};
    offer(11'h400, 1'b0, 4'h0, 2'h0);
    @(posedge clk) {en, ack_en, req} <= {11'h7ff, 1'b1, 11'h000};
    $display("test arbitration done");
    offer(11'h001, 1'b1, 4'h0, 2'h1);
    offer(11'h005, 1'b0, 4'h0, 2'h0);
    chk(svc, 4'h2);
    offer(11'h007, 1'b1, 4'h1, 2'h2);
    offer(11'h407, 1'b1, 4'ha, 2'h3);
    offer(11'h7ff, 1'b0, 4'h0, 2'h0);
    chk(svc, 4'he);
    rreg(8'hf6, 8'h6e);
    @(posedge clk) ack_en <= 1'b0;
    repeat (3) begin
      @(posedge clk) ret <= 1'b1;
      @(posedge clk) ret <= 1'b0;
    end
    repeat (2) @(posedge clk);
    #1 chk({svc, req_o, src}, {4'h0, 1'b1, 4'ha});
    $display("test preemption done");
    // Dropping every high bit of register B leaves timer 0 on top
    wreg(8'hf7, 8'h00);
    #1 chk({req_o, src, lvl}, {1'b1, 4'ha, 2'h3});
    @(posedge clk);
    #1 chk({req_o, src, lvl}, {1'b1, 4'h1, 2'h2});
    $display("test write timing done");
    give_verdict();
  end
endmodule
bind iplr_regs iplr_checker iplr_checker_i (
  .core_clk_in(core_clk_in),
  .nrst_in(nrst_in),
  .sfr_addr_in(sfr_addr_in),
  .sfr_wdata_in(sfr_wdata_in),
  .sfr_wr_in(sfr_wr_in),
  .bit_addr_in(bit_addr_in),
  .bit_val_in(bit_val_in),
  .bit_wr_in(bit_wr_in),
  .src_req_in(src_req_in),
  .src_en_in(src_en_in),
  .global_irq_enable_in(global_irq_enable_in),
  .irq_req_out(irq_req_out),
  .irq_src_out(irq_src_out),
  .irq_level_out(irq_level_out),
  .src_level_out(src_level_out),
  .svc_active_out(svc_active_out)
);
